// File: core/pif_pkg.sv
// Constants for the peripheral interrupt flag and enable block.
// Assumes a single 40 MHz clock and an AXI4-Lite register master.
// Function
// [RULE1] Flags set regardless of enables or global disable
// [RULE2] Software clears flag before enabling its source
// [RULE3] Enable group two at 11h, listed bits
// [RULE4] Request group one at 16h, listed bits
// [RULE5] Port change sets flag; software ends mismatch
// [RULE6] Select one: timer3 flag on overflow
// [RULE7] Select zero: timer3 flag on period rollover
// [RULE8] Timer2 flag on period match rollover
// [RULE9] Eight-bit mode: timer1 flag on period rollover
// [RULE10] Sixteen-bit mode: pair rollover sets timer1 flag
// [RULE11] Capture2 event sets capture2 flag
// [RULE12] Capture1 event sets capture1 flag
// [RULE13] Serial1 transmit flag shows buffer empty
// [RULE14] Serial1 receive flag shows buffer full
// [RULE15] Pending is OR of flag AND enable
// [RULE16] Enable bit four reads zero, ignores writes
// [RULE17] Write zero clears flag; set event wins
package pif_pkg;
    // ========================================
    // Register offsets (printed offsets are indices)
    localparam logic [7:0]  ENABLE2_IDX      = 8'h11;
    localparam logic [7:0]  REQUEST1_IDX     = 8'h16;
    localparam logic [7:0]  ENABLE1_IDX      = 8'h17;
    localparam logic [7:0]  CONTROL_IDX      = 8'h20;
    localparam logic [7:0]  STATUS_IDX       = 8'h21;
    localparam logic [7:0]  MASK_IDX         = 8'h22;
    localparam logic [7:0]  PERIOD_IDX       = 8'h23;
    localparam logic [7:0]  TIMER_IDX        = 8'h24;
    // ========================================
    // Reset values and masks
    localparam logic [7:0]  ENABLE2_RESET    = 8'h00;
    localparam logic [7:0]  ENABLE2_MASK     = 8'hEF;
    localparam logic [7:0]  REQUEST1_RESET   = 8'h00;
    localparam logic [7:0]  REQUEST1_WMASK   = 8'hFC;
    // ========================================
    // Field positions of request group one
    localparam int PORT_CHANGE_BIT  = 7;
    localparam int TIMER3_BIT       = 6;
    localparam int TIMER2_BIT       = 5;
    localparam int TIMER1_BIT       = 4;
    localparam int CAPTURE2_BIT     = 3;
    localparam int CAPTURE1_BIT     = 2;
    localparam int SERIAL1_TX_BIT   = 1;
    localparam int SERIAL1_RX_BIT   = 0;
    // Control fields
    localparam int CAP1_SELECT_BIT  = 0;
    localparam int PAIR16_BIT       = 1;
    localparam int TIMER_RUN_BIT    = 2;
    // ========================================
    // Bus answers and change watch port width
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;
    localparam int          WATCH_WIDTH      = 4;
endpackage

// File: core/pif_timer_set.sv
// Timer block producing the timer flag set pulses.
// Assumes same-clock control inputs and a clock enable.
`timescale 1ns/1ps
module pif_timer_set
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        clockEn,
    input  wire logic        run,
    input  wire logic        pair16,
    input  wire logic        cap1Select,
    input  wire logic [7:0]  timer1Period,
    input  wire logic [7:0]  timer2Period,
    input  wire logic [15:0] timer3PeriodPair,
    output logic      [7:0]  timer1,
    output logic      [7:0]  timer2,
    output logic      [15:0] timer3,
    output logic             timer1Set,
    output logic             timer2Set,
    output logic             timer3Set
);
    typedef struct packed {
        logic [7:0]  t1;
        logic [7:0]  t2;
        logic [15:0] t3;
        logic        s1;
        logic        s2;
        logic        s3;
    } pif_tstate_t;

    pif_tstate_t st;
    pif_tstate_t next_st;
    logic        t1Match;
    logic        t2Match;
    logic        pairMatch;
    logic        t3Match;

    assign t1Match   = st.t1 == timer1Period;
    assign t2Match   = st.t2 == timer2Period;
    assign pairMatch = {st.t2, st.t1} == {timer2Period, timer1Period};
    assign t3Match   = st.t3 == timer3PeriodPair;

    always_comb
    begin
        next_st    = st;
        next_st.s1 = 1'b0;
        next_st.s2 = 1'b0;
        next_st.s3 = 1'b0;
        if (run)
        begin
            if (pair16)
            begin
                {next_st.t2, next_st.t1} = pairMatch ? 16'h0000 : {st.t2, st.t1} + 16'h0001;
                next_st.s1 = pairMatch; // [RULE10]
            end
            else
            begin
                next_st.t1 = t1Match ? 8'h00 : st.t1 + 8'h01;
                next_st.s1 = t1Match; // [RULE9]
                next_st.t2 = t2Match ? 8'h00 : st.t2 + 8'h01;
                next_st.s2 = t2Match; // [RULE8]
            end
            if (cap1Select)
            begin
                next_st.t3 = st.t3 + 16'h0001;
                next_st.s3 = st.t3 == 16'hFFFF; // [RULE6]
            end
            else
            begin
                next_st.t3 = t3Match ? 16'h0000 : st.t3 + 16'h0001;
                next_st.s3 = t3Match; // [RULE7]
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            st <= '0;
        else if (clockEn)
            st <= next_st;
    end

    assign timer1    = st.t1;
    assign timer2    = st.t2;
    assign timer3    = st.t3;
    assign timer1Set = st.s1 & clockEn;
    assign timer2Set = st.s2 & clockEn;
    assign timer3Set = st.s3 & clockEn;

    a_timer2_wrap: assert property (@(posedge clock) disable iff (rst)
        timer2Set |-> st.t2 == 8'h00) else $error("timer2 set without wrap"); // [RULE8]
    a_timer3_wrap: assert property (@(posedge clock) disable iff (rst)
        timer3Set |-> st.t3 == 16'h0000) else $error("timer3 set without wrap"); // [RULE7]
endmodule

// File: core/pif_irq_flags.sv
// Peripheral flag and enable registers on an AXI4-Lite slave.
// Assumes pins are asynchronous; serial status comes from same clock.
`timescale 1ns/1ps
module pif_irq_flags
(
    input  wire logic                           clock,
    input  wire logic                           rst,
    input  wire logic                           clockEn,
    input  wire logic [11:0]                    awaddr,
    input  wire logic                           awvalid,
    output logic                                awready,
    input  wire logic [31:0]                    wdata,
    input  wire logic [3:0]                     wstrb,
    input  wire logic                           wvalid,
    output logic                                wready,
    output logic      [1:0]                     bresp,
    output logic                                bvalid,
    input  wire logic                           bready,
    input  wire logic [11:0]                    araddr,
    input  wire logic                           arvalid,
    output logic                                arready,
    output logic      [31:0]                    rdata,
    output logic      [1:0]                     rresp,
    output logic                                rvalid,
    input  wire logic                           rready,
    input  wire logic [pif_pkg::WATCH_WIDTH-1:0] changeWatchPort,
    input  wire logic                           capture1Pin,
    input  wire logic                           capture2Pin,
    input  wire logic                           serial1TxEmpty,
    input  wire logic                           serial1RxFull,
    input  wire logic [6:0]                     group2Events,
    output logic                                peripheralPending,
    output logic                                irq
);
    localparam int WW = pif_pkg::WATCH_WIDTH;
    initial
    begin
        if (WW < 1 || WW > 8)
            $error("watch width out of range");
    end

    typedef struct packed {
        logic [WW-1:0] pSync1;
        logic [WW-1:0] pSync2;
        logic [WW-1:0] pLatch;
        logic [1:0]    c1Sync;
        logic [1:0]    c2Sync;
        logic          c1Prev;
        logic          c2Prev;
        logic [7:0]    enable1;
        logic [7:0]    enable2;
        logic [5:0]    request;
        logic [2:0]    control;
        logic [1:0]    status;
        logic [1:0]    mask;
        logic [7:0]    per1;
        logic [7:0]    per2;
        logic [15:0]   per3;
        logic          awHeld;
        logic [11:0]   awAddr;
        logic          wHeld;
        logic [31:0]   wData;
        logic [3:0]    wStrb;
        logic          bValid;
        logic [1:0]    bResp;
        logic          rValid;
        logic [31:0]   rData;
        logic [1:0]    rResp;
    } pif_state_t;

    pif_state_t st;
    pif_state_t next_st;
    logic [7:0] t1;
    logic [7:0] t2;
    logic [15:0] t3;
    logic       t1Set;
    logic       t2Set;
    logic       t3Set;
    logic [7:0] request1;
    logic [5:0] hwSet;

    // ========================================
    // Index decode shared by read and write
    function automatic logic [7:0] reg_index(input logic [11:0] a);
        reg_index = a[9:2];
    endfunction

    function automatic logic is_mapped(input logic [7:0] i);
        is_mapped = i == pif_pkg::ENABLE2_IDX || i == pif_pkg::REQUEST1_IDX
            || i == pif_pkg::ENABLE1_IDX || i == pif_pkg::CONTROL_IDX
            || i == pif_pkg::STATUS_IDX || i == pif_pkg::MASK_IDX
            || i == pif_pkg::PERIOD_IDX || i == pif_pkg::TIMER_IDX;
    endfunction

    pif_timer_set timers
    (
        .clock            (clock),
        .rst              (rst),
        .clockEn          (clockEn),
        .run              (st.control[pif_pkg::TIMER_RUN_BIT]),
        .pair16           (st.control[pif_pkg::PAIR16_BIT]),
        .cap1Select       (st.control[pif_pkg::CAP1_SELECT_BIT]),
        .timer1Period     (st.per1),
        .timer2Period     (st.per2),
        .timer3PeriodPair (st.per3),
        .timer1           (t1),
        .timer2           (t2),
        .timer3           (t3),
        .timer1Set        (t1Set),
        .timer2Set        (t2Set),
        .timer3Set        (t3Set)
    );

    // ========================================
    // Request register view
    assign request1 = {st.request, serial1TxEmpty, serial1RxFull}; // [RULE4] [RULE13] [RULE14]
    // Flag set events, independent of the enable registers
    assign hwSet = {st.pSync2 != st.pLatch, t3Set, t2Set, t1Set,
                    st.c2Sync[1] & ~st.c2Prev, st.c1Sync[1] & ~st.c1Prev}; // [RULE1]

    always_comb
    begin
        logic       doWrite;
        logic [7:0] wIdx;
        logic [7:0] wByte;
        logic [5:0] clr;
        logic [7:0] rIdx;
        logic [1:0] ev;
        doWrite = 1'b0;
        wIdx    = 8'h00;
        wByte   = 8'h00;
        clr     = 6'h00;
        rIdx    = 8'h00;
        ev      = 2'h0;
        next_st = st;
        next_st.pSync1 = changeWatchPort;
        next_st.pSync2 = st.pSync1;
        next_st.c1Sync = {st.c1Sync[0], capture1Pin};
        next_st.c2Sync = {st.c2Sync[0], capture2Pin};
        next_st.c1Prev = st.c1Sync[1];
        next_st.c2Prev = st.c2Sync[1];
        if (awvalid && !st.awHeld)
        begin
            next_st.awHeld = 1'b1;
            next_st.awAddr = awaddr;
        end
        if (wvalid && !st.wHeld)
        begin
            next_st.wHeld = 1'b1;
            next_st.wData = wdata;
            next_st.wStrb = wstrb;
        end
        if (st.bValid && bready)
            next_st.bValid = 1'b0;
        if (st.awHeld && st.wHeld && !st.bValid)
        begin
            doWrite = st.wStrb[0];
            wIdx    = reg_index(st.awAddr);
            wByte   = st.wData[7:0];
            next_st.awHeld = 1'b0;
            next_st.wHeld  = 1'b0;
            next_st.bValid = 1'b1;
            next_st.bResp  = is_mapped(wIdx) ? pif_pkg::RESP_OKAY : pif_pkg::RESP_SLVERR;
        end
        if (doWrite)
        begin
            case (wIdx)
                pif_pkg::ENABLE2_IDX:
                    next_st.enable2 = wByte & pif_pkg::ENABLE2_MASK; // [RULE3] [RULE16]
                pif_pkg::REQUEST1_IDX:
                begin
                    clr = ~wByte[7:2]; // [RULE17]
                    // Writing zero to the port change bit ends the mismatch
                    if (!wByte[pif_pkg::PORT_CHANGE_BIT])
                        next_st.pLatch = st.pSync2; // [RULE5]
                end
                pif_pkg::ENABLE1_IDX:
                    next_st.enable1 = wByte;
                pif_pkg::CONTROL_IDX:
                    next_st.control = wByte[2:0];
                pif_pkg::STATUS_IDX:
                    ev = wByte[1:0];
                pif_pkg::MASK_IDX:
                    next_st.mask = wByte[1:0];
                pif_pkg::PERIOD_IDX:
                begin
                    if (st.wStrb[1])
                        next_st.per1 = st.wData[15:8];
                    next_st.per2 = wByte;
                end
                default:
                    next_st.per3 = next_st.per3;
            endcase
            if (wIdx == pif_pkg::PERIOD_IDX && st.wStrb[3])
                next_st.per3 = st.wData[31:16];
        end
        next_st.request = (st.request & ~clr) | hwSet; // [RULE17] [RULE1]
        next_st.status  = (st.status & ~ev) | {|hwSet, t3Set | t2Set | t1Set};
        if (st.rValid && rready)
            next_st.rValid = 1'b0;
        if (arvalid && !st.rValid)
        begin
            rIdx = reg_index(araddr);
            next_st.rValid = 1'b1;
            next_st.rResp  = is_mapped(rIdx) ? pif_pkg::RESP_OKAY : pif_pkg::RESP_SLVERR;
            case (rIdx)
                pif_pkg::ENABLE2_IDX:  next_st.rData = {24'h000000, st.enable2};
                pif_pkg::REQUEST1_IDX: next_st.rData = {24'h000000, request1};
                pif_pkg::ENABLE1_IDX:  next_st.rData = {24'h000000, st.enable1};
                pif_pkg::CONTROL_IDX:  next_st.rData = {29'h0000000, st.control};
                pif_pkg::STATUS_IDX:   next_st.rData = {30'h0000000, st.status};
                pif_pkg::MASK_IDX:     next_st.rData = {30'h0000000, st.mask};
                pif_pkg::PERIOD_IDX:   next_st.rData = {st.per3, st.per1, st.per2};
                pif_pkg::TIMER_IDX:    next_st.rData = {t3, t1, t2};
                default:               next_st.rData = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            st         <= '0;
            st.enable2 <= pif_pkg::ENABLE2_RESET;
            st.request <= pif_pkg::REQUEST1_RESET[7:2];
        end
        else if (clockEn)
            st <= next_st;
    end

    // No address, write data or read address handshake is offered while state is frozen
    assign awready = !st.awHeld && clockEn;
    assign wready  = !st.wHeld && clockEn;
    assign bvalid  = st.bValid;
    assign bresp   = st.bResp;
    assign arready = !st.rValid && clockEn;
    assign rvalid  = st.rValid;
    assign rdata   = st.rData;
    assign rresp   = st.rResp;
    assign peripheralPending = |(request1 & st.enable1); // [RULE15]
    assign irq = |(st.status & st.mask);

    a_set_wins: assert property (@(posedge clock) disable iff (rst)
        clockEn && hwSet[0] |=> st.request[0]) else $error("set lost"); // [RULE17]
    a_enable_bit4: assert property (@(posedge clock) disable iff (rst)
        st.enable2[4] == 1'b0) else $error("bit four set"); // [RULE16]
    a_pending_or: assert property (@(posedge clock) disable iff (rst)
        peripheralPending == |(request1 & st.enable1)) else $error("pending bad"); // [RULE15]
    a_cap1_flag: assert property (@(posedge clock) disable iff (rst)
        clockEn && st.c1Sync[1] && !st.c1Prev |=> st.request[0]) else $error("cap1"); // [RULE12]
    a_cap2_flag: assert property (@(posedge clock) disable iff (rst)
        clockEn && st.c2Sync[1] && !st.c2Prev |=> st.request[1]) else $error("cap2"); // [RULE11]
    a_port_flag: assert property (@(posedge clock) disable iff (rst)
        clockEn && st.pSync2 != st.pLatch |=> st.request[5]) else $error("port"); // [RULE5]
    a_timer1_flag: assert property (@(posedge clock) disable iff (rst)
        clockEn && t1Set |=> st.request[2]) else $error("timer1"); // [RULE9]
    a_flags_ro: assert property (@(posedge clock) disable iff (rst)
        request1[1:0] == {serial1TxEmpty, serial1RxFull}) else $error("serial"); // [RULE13]
    a_write_resp: assert property (@(posedge clock) disable iff (rst)
        clockEn && st.awHeld && st.wHeld && !st.bValid |=> bvalid) else $error("bresp");
    c_port_change: cover property (@(posedge clock) hwSet[5]);
    c_timer3_set: cover property (@(posedge clock) t3Set);
    c_pending: cover property (@(posedge clock) peripheralPending);
endmodule

// File: test/pif_periph_model.sv
// Peripheral event sources facing the flag block.
// Assumes the bench calls these tasks from one process.
`timescale 1ns/1ps
module pif_periph_model
(
    input  wire logic                            clock,
    output logic      [pif_pkg::WATCH_WIDTH-1:0] changeWatchPort,
    output logic                                 capture1Pin,
    output logic                                 capture2Pin,
    output logic                                 serial1TxEmpty,
    output logic                                 serial1RxFull
);
    initial
    begin
        changeWatchPort = '0;
        capture1Pin = 1'b0;
        capture2Pin = 1'b0;
        serial1TxEmpty = 1'b0;
        serial1RxFull = 1'b0;
    end
    // ========================================
    // Capture edge held four cycles
    task automatic capture(input int n);
        begin
            @(posedge clock);
            if (n == 1)
                capture1Pin <= 1'b1;
            else
                capture2Pin <= 1'b1;
            repeat (4) @(posedge clock);
            capture1Pin <= 1'b0;
            capture2Pin <= 1'b0;
        end
    endtask
    task automatic portChange(input logic [pif_pkg::WATCH_WIDTH-1:0] v);
        @(posedge clock);
        changeWatchPort <= v;
    endtask
    // Buffer levels
    task automatic serial(input logic tx, input logic rx);
        @(posedge clock);
        serial1TxEmpty <= tx;
        serial1RxFull <= rx;
    endtask
endmodule

// File: test/pif_irq_flags_tb.sv
// Self-checking bench of the flag and enable block.
// Assumes the peripheral model drives all event pins but group2Events, which the bench drives.
`timescale 1ns/1ps
module pif_irq_flags_tb;
    logic        clock, rst, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        peripheralPending, irq;
    logic        capture1Pin, capture2Pin, serial1TxEmpty, serial1RxFull;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd, d;
    logic [3:0]  wstrb;
    logic        clockEn;
    logic [6:0]  group2Events;
    logic [1:0]  bresp, rresp, rs;
    logic [7:0]  mReq, mEn1, mEn2;
    logic [pif_pkg::WATCH_WIDTH-1:0] changeWatchPort;
    int          errors, testsRun, cyc, seed, k;

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    pif_irq_flags DUT
    (
        .clock, .rst, .clockEn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .changeWatchPort, .capture1Pin,
        .capture2Pin, .serial1TxEmpty, .serial1RxFull, .group2Events,
        .peripheralPending, .irq
    );
    pif_periph_model PER
    (
        .clock, .changeWatchPort, .capture1Pin, .capture2Pin, .serial1TxEmpty,
        .serial1RxFull
    );

    // ========================================
    // Reporting
    task automatic endOfTest();
        $display("errors %0d comparisons %0d", errors, testsRun);
        if (errors == 0 && testsRun > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cmpReg(input string n, input logic [31:0] e, input logic [31:0] g);
        testsRun++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmpBit(input string n, input logic e, input logic g);
        testsRun++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic sigChk(input string n, input logic e);
        @(negedge clock);
        cmpBit(n, e, (n == "irq") ? irq : peripheralPending);
    endtask
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            endOfTest();
        end
    end

    // ========================================
    // AXI4-Lite master
    task automatic axWrite(input logic [7:0] i, input logic [31:0] v);
        logic pa, pw, a, w, b;
        begin
            @(posedge clock);
            awaddr <= {2'h0, i, 2'h0};
            wdata <= v;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            pa = 1'b1;
            pw = 1'b1;
            b = 1'b0;
            while (!b)
            begin
                @(negedge clock);
                a = awready;
                w = wready;
                b = bvalid;
                rs = bresp;
                @(posedge clock);
                if (pa && a)
                    awvalid <= 1'b0;
                if (pw && w)
                    wvalid <= 1'b0;
                pa = pa && !a;
                pw = pw && !w;
            end
            bready <= 1'b0;
        end
    endtask
    task automatic axRead(input logic [7:0] i);
        logic pa, a, r;
        begin
            @(posedge clock);
            araddr <= {2'h0, i, 2'h0};
            arvalid <= 1'b1;
            rready <= 1'b1;
            pa = 1'b1;
            r = 1'b0;
            while (!r)
            begin
                @(negedge clock);
                a = arready;
                r = rvalid;
                rd = rdata;
                rs = rresp;
                @(posedge clock);
                if (pa && a)
                    arvalid <= 1'b0;
                pa = pa && !a;
            end
            rready <= 1'b0;
        end
    endtask
    function automatic logic [7:0] expReq();
        return {mReq[7:2], serial1TxEmpty, serial1RxFull};
    endfunction
    task automatic rdChk(input string n, input logic [7:0] i, input logic [31:0] e);
        axRead(i);
        cmpReg(n, e, rd);
    endtask

    // ========================================
    // Main sequence
    initial
    begin
        seed = 32'hC360;
        {errors, testsRun, cyc} = '0;
        {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        clockEn = 1'b1;
        group2Events = 7'h00;
        {mReq, mEn1, mEn2} = '0;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        rdChk("enable2", pif_pkg::ENABLE2_IDX, 32'h0);
        rdChk("request1", pif_pkg::REQUEST1_IDX, 32'h0);
        for (k = 0; k < 5; k++)
        begin
            d = (k == 0) ? 32'h000000FF : $random(seed);
            axWrite(pif_pkg::ENABLE2_IDX, d);
            mEn2 = d[7:0] & 8'hEF;
            group2Events <= d[6:0];
            rdChk("enable2", pif_pkg::ENABLE2_IDX, {24'h0, mEn2});
        end
        for (k = 0; k < 4; k++)
        begin
            PER.serial(k[1], k[0]);
            axWrite(pif_pkg::REQUEST1_IDX, 32'h0);
            rdChk("request1", pif_pkg::REQUEST1_IDX, {24'h0, expReq()});
        end
        PER.capture(1);
        repeat (8) @(posedge clock);
        mReq[2] = 1'b1;
        rdChk("request1", pif_pkg::REQUEST1_IDX, {24'h0, expReq()});
        sigChk("pending", 1'b0);
        PER.capture(2);
        repeat (8) @(posedge clock);
        mReq[3] = 1'b1;
        rdChk("request1", pif_pkg::REQUEST1_IDX, {24'h0, expReq()});
        for (k = 0; k < 8; k++)
        begin
            mEn1 = 8'h01 << k;
            axWrite(pif_pkg::ENABLE1_IDX, {24'h0, mEn1});
            sigChk("pending", |(expReq() & mEn1));
        end
        axWrite(pif_pkg::REQUEST1_IDX, 32'h000000F7);
        mReq[3] = 1'b0;
        rdChk("request1", pif_pkg::REQUEST1_IDX, {24'h0, expReq()});
        PER.portChange(4'h5);
        repeat (8) @(posedge clock);
        mReq[7] = 1'b1;
        rdChk("request1", pif_pkg::REQUEST1_IDX, {24'h0, expReq()});
        sigChk("pending", 1'b1);
        axWrite(pif_pkg::REQUEST1_IDX, 32'h0000007F);
        rdChk("request1", pif_pkg::REQUEST1_IDX, {24'h0, expReq()});
        axWrite(pif_pkg::REQUEST1_IDX, 32'h0000007F);
        mReq[7] = 1'b0;
        repeat (8) @(posedge clock);
        rdChk("request1", pif_pkg::REQUEST1_IDX, {24'h0, expReq()});
        axWrite(pif_pkg::PERIOD_IDX, 32'h00030303);
        axWrite(pif_pkg::CONTROL_IDX, 32'h4);
        axWrite(pif_pkg::REQUEST1_IDX, 32'h0);
        repeat (40) @(posedge clock);
        mReq = 8'h70;
        rdChk("request1", pif_pkg::REQUEST1_IDX, {24'h0, expReq()});
        axWrite(pif_pkg::CONTROL_IDX, 32'h5);
        axWrite(pif_pkg::REQUEST1_IDX, 32'h0);
        repeat (40) @(posedge clock);
        mReq = 8'h30;
        rdChk("request1", pif_pkg::REQUEST1_IDX, {24'h0, expReq()});
        axWrite(pif_pkg::CONTROL_IDX, 32'h7);
        axWrite(pif_pkg::REQUEST1_IDX, 32'h0);
        repeat (900) @(posedge clock);
        mReq = 8'h10;
        rdChk("request1", pif_pkg::REQUEST1_IDX, {24'h0, expReq()});
        axWrite(pif_pkg::CONTROL_IDX, 32'h0);
        axWrite(pif_pkg::STATUS_IDX, 32'hFFFFFFFF);
        axWrite(pif_pkg::MASK_IDX, 32'h2);
        rdChk("status", pif_pkg::STATUS_IDX, 32'h0);
        sigChk("irq", 1'b0);
        PER.capture(1);
        repeat (8) @(posedge clock);
        rdChk("status", pif_pkg::STATUS_IDX, 32'h2);
        sigChk("irq", 1'b1);
        axWrite(pif_pkg::MASK_IDX, 32'h0);
        sigChk("irq", 1'b0);
        axWrite(pif_pkg::MASK_IDX, 32'h2);
        axWrite(pif_pkg::STATUS_IDX, 32'h2);
        rdChk("status", pif_pkg::STATUS_IDX, 32'h0);
        sigChk("irq", 1'b0);
        // Capture edge while frozen is not seen
        mReq[2] = 1'b1;
        @(posedge clock);
        clockEn <= 1'b0;
        PER.capture(2);
        repeat (8) @(posedge clock);
        clockEn <= 1'b1;
        repeat (4) @(posedge clock);
        rdChk("request1", pif_pkg::REQUEST1_IDX, {24'h0, expReq()});
        axRead(8'h3F);
        cmpReg("rresp", {30'h0, pif_pkg::RESP_SLVERR}, {30'h0, rs});
        cmpReg("rdata", 32'h0, rd);
        axWrite(8'h3F, 32'h1);
        cmpReg("bresp", {30'h0, pif_pkg::RESP_SLVERR}, {30'h0, rs});
        endOfTest();
    end
endmodule
